// ==== core/lsi_consts.svh ====
// constants, register map and field layout of the lin slave interface
// Contract
// (RL1) prescaler field bits 6:4 sets receive filter length in module clocks
// (RL2) pulses shorter than the filter length are ignored as noise
// (RL3) wait clock mode bit 3 is writable once after reset only
// (RL4) wait clock mode keeps clocks running in cpu wait, else stops them
// (RL5) software writes wait clock mode before first enabling the module
// (RL6) byte transfer mode bit 2 bypasses framing, sends single bytes half duplex
// (RL7) in byte mode bit time register gives module clocks per bit; the code takes the register value plus one clocks per bit
// (RL8) software sets bit time register before byte mode traffic
// (RL9) clearing byte mode during transmission halts it at once
// (RL10) byte mode treats any data length as one byte, checksum disabled
// (RL11) byte mode format is fixed eight data bits, no parity, one stop
// (RL12) enable bit 0 gates the module clock, 1 enables
// (RL13) stop bit sampled as 0 flags a byte framing error
// (RL14) good identifier goes to buffer, flag clears only on buffer read
// (RL15) identifier parity error flagged, identifier still reported in buffer
// (RL16) after parity error frame discarded until next header
// (RL17) wake-up source raised on passage from stop to run mode
// (RL18) byte mode uses subset of sources with same codes and priorities
// (RL19) byte mode codes 00,0C,14,18,1C with priorities 0,3,5,6,7
// (RL20) status vector shows highest priority pending code, zero if none
`ifndef LSI_CONSTS_SVH
`define LSI_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSI_OFF_CTRL2 4'h0
`define LSI_OFF_BITTIME 4'h1
`define LSI_OFF_DLEN 4'h2
`define LSI_OFF_IDBUF 4'h3
`define LSI_OFF_SV 4'h4
`define LSI_OFF_TXD 4'h5
`define LSI_OFF_RXD 4'h6
// ----------------------------------------
// control field positions and reset values
// ----------------------------------------
`define LSI_FP_HI 6
`define LSI_FP_LO 4
`define LSI_WCM_BIT 3
`define LSI_BTM_BIT 2
`define LSI_EN_BIT 0
`define LSI_CTRL2_RST 8'h00
`define LSI_BITTIME_RST 8'h10
`define LSI_BREAK_BITS 4'hB
// ----------------------------------------
// status vector codes
// ----------------------------------------
`define LSI_SV_NONE 8'h00
`define LSI_SV_FRAME 8'h04
`define LSI_SV_WAKE 8'h08
`define LSI_SV_TXE 8'h0C
`define LSI_SV_IDPAR 8'h10
`define LSI_SV_RXF 8'h14
`define LSI_SV_BITERR 8'h18
`define LSI_SV_OVR 8'h1C
`define LSI_SV_IDOK 8'h20
`endif

// ==== core/lsi_pkg.sv ====
// types shared by the lin slave interface
package lsi_pkg;
  typedef enum logic [1:0] {
    LSI_RX_IDLE = 2'b00,
    LSI_RX_START = 2'b01,
    LSI_RX_DATA = 2'b10,
    LSI_RX_STOP = 2'b11
  } lsi_rx_state_t;
  typedef struct packed {
    logic [2:0] prescale;
    logic wait_clock;
    logic byte_mode;
    logic enable;
  } lsi_ctrl_t;
  typedef struct packed {
    logic frame;
    logic wake;
    logic txe;
    logic idpar;
    logic rxf;
    logic biterr;
    logic ovr;
    logic idok;
  } lsi_src_t;
endpackage

// ==== core/lsi_top.sv ====
// lin slave interface: control register, filter, byte engine, status vector
//
// Decided for this implementation: the strobed register port and the register addresses.
`include "lsi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lsi_top (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // system
  input wire logic cpu_wait_in,
  input wire logic stop_in,
  // bus pin
  input wire logic lin_rx_in,
  output logic lin_tx_out,
  output logic lin_tx_oe_out,
  // status
  output logic mod_clk_en_out,
  output logic [7:0] sv_out
);
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  lsi_pkg::lsi_ctrl_t ctrl_r;
  logic wcm_done_r;
  logic [7:0] bittime_r;
  logic [3:0] dlen_r;
  logic [7:0] txd_r;
  logic [7:0] rxd_r;
  logic [7:0] idbuf_r;
  lsi_pkg::lsi_src_t src_r;
  logic [7:0] sv_nxt;
  logic [7:0] sv_r;
  logic tx_busy_r;
  logic run;
  logic wr_c2;
  assign wr_c2 = wr_in && (addr_in == `LSI_OFF_CTRL2);
  // wait clock gating: stopped in wait unless wait clock mode set
  assign run = ce_in && ctrl_r.enable && !(cpu_wait_in && !ctrl_r.wait_clock); // see (RL12) see (RL4)

  // control register; the wait clock bit locks after its first write
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= lsi_pkg::lsi_ctrl_t'(6'h00);
      wcm_done_r <= 1'b0;
    end else if (ce_in && wr_c2) begin
      ctrl_r.prescale <= wdata_in[`LSI_FP_HI:`LSI_FP_LO]; // see (RL1)
      ctrl_r.byte_mode <= wdata_in[`LSI_BTM_BIT]; // see (RL6)
      ctrl_r.enable <= wdata_in[`LSI_EN_BIT]; // see (RL12)
      if (!wcm_done_r) begin
        ctrl_r.wait_clock <= wdata_in[`LSI_WCM_BIT]; // see (RL3)
        wcm_done_r <= 1'b1;
      end
    end
  end

  // plain data registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bittime_r <= `LSI_BITTIME_RST;
      dlen_r <= 4'h0;
    end else if (ce_in && wr_in) begin
      if (addr_in == `LSI_OFF_BITTIME) bittime_r <= wdata_in; // see (RL7)
      if (addr_in == `LSI_OFF_DLEN) dlen_r <= wdata_in[3:0];
    end
  end

  // ----------------------------------------
  // receive synchroniser and noise filter
  // ----------------------------------------
  logic rx_s1_r, rx_s2_r, rx_f_r;
  logic [7:0] filt_cnt_r;
  logic [7:0] filt_len;
  assign filt_len = 8'(8'h01 << ctrl_r.prescale); // see (RL1)
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else if (ce_in) begin
      rx_s1_r <= lin_rx_in;
      rx_s2_r <= rx_s1_r;
    end
  end
  // filter output moves only after the input held steady for filt_len clocks
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_f_r <= 1'b1;
      filt_cnt_r <= 8'h00;
    end else if (run) begin
      if (rx_s2_r == rx_f_r) begin
        filt_cnt_r <= 8'h00; // short pulse dropped, see (RL2)
      end else if (filt_cnt_r + 8'h01 >= filt_len) begin
        rx_f_r <= rx_s2_r;
        filt_cnt_r <= 8'h00;
      end else begin
        filt_cnt_r <= filt_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // receiver, 8-N-1 bit engine
  // ----------------------------------------
  lsi_pkg::lsi_rx_state_t rx_st_r;
  logic [7:0] rx_bt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic [3:0] zero_run_r;
  logic [1:0] hdr_r; // 0 wait break, 1 sync, 2 id, 3 data
  logic [3:0] data_cnt_r;
  logic rx_done;
  logic rx_stop_ok;
  logic id_par_ok;
  logic [7:0] rx_half;
  logic brk;
  assign rx_half = {1'b0, bittime_r[7:1]};
  assign rx_done = run && (rx_st_r == lsi_pkg::LSI_RX_STOP) && (rx_bt_r == bittime_r);
  assign rx_stop_ok = rx_f_r; // see (RL13)
  // lin protected id: p0 = i0^i1^i2^i4, p1 = ~(i1^i3^i4^i5)
  assign id_par_ok = (rx_sh_r[6] == (rx_sh_r[0] ^ rx_sh_r[1] ^ rx_sh_r[2] ^ rx_sh_r[4])) &&
                     (rx_sh_r[7] == ~(rx_sh_r[1] ^ rx_sh_r[3] ^ rx_sh_r[4] ^ rx_sh_r[5]));

  // bit sampler: centre of each bit, one stop bit, no parity
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_r <= lsi_pkg::LSI_RX_IDLE;
      rx_bt_r <= 8'h00;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
    end else if (run && brk) begin
      // park during a break so its tail is not taken for the sync byte
      rx_st_r <= lsi_pkg::LSI_RX_IDLE;
      rx_bt_r <= 8'h00;
    end else if (run) begin
      case (rx_st_r)
        lsi_pkg::LSI_RX_IDLE: begin
          rx_bt_r <= 8'h00;
          if (!rx_f_r && !tx_busy_r) rx_st_r <= lsi_pkg::LSI_RX_START; // half duplex, see (RL6)
        end
        lsi_pkg::LSI_RX_START: begin
          rx_bt_r <= rx_bt_r + 8'h01;
          if (rx_bt_r == rx_half) begin
            rx_bt_r <= 8'h00;
            rx_bit_r <= 3'h0;
            rx_st_r <= rx_f_r ? lsi_pkg::LSI_RX_IDLE : lsi_pkg::LSI_RX_DATA;
          end
        end
        lsi_pkg::LSI_RX_DATA: begin
          rx_bt_r <= rx_bt_r + 8'h01;
          if (rx_bt_r == bittime_r) begin
            rx_bt_r <= 8'h00;
            rx_sh_r <= {rx_f_r, rx_sh_r[7:1]}; // lsb first, see (RL11)
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7) rx_st_r <= lsi_pkg::LSI_RX_STOP;
          end
        end
        lsi_pkg::LSI_RX_STOP: begin
          rx_bt_r <= rx_bt_r + 8'h01;
          if (rx_done) rx_st_r <= lsi_pkg::LSI_RX_IDLE;
        end
        default: rx_st_r <= lsi_pkg::LSI_RX_IDLE;
      endcase
    end
  end

  // break detector: a long dominant run restarts header search
  assign brk = (zero_run_r >= `LSI_BREAK_BITS);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      zero_run_r <= 4'h0;
    end else if (run) begin
      if (rx_f_r) zero_run_r <= 4'h0;
      else if (rx_bt_r == bittime_r && !brk) zero_run_r <= zero_run_r + 4'h1;
    end
  end

  // frame sequencer: break, sync, id, data bytes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hdr_r <= 2'h0;
      data_cnt_r <= 4'h0;
    end else if (run) begin
      if (ctrl_r.byte_mode) begin
        hdr_r <= 2'h0; // framing bypassed, see (RL6)
      end else if (brk) begin
        hdr_r <= 2'h1;
      end else if (rx_done) begin
        case (hdr_r)
          2'h1: hdr_r <= 2'h2;
          2'h2: begin
            hdr_r <= id_par_ok ? 2'h3 : 2'h0; // discard frame, see (RL16)
            data_cnt_r <= 4'h0;
          end
          2'h3: begin
            data_cnt_r <= data_cnt_r + 4'h1;
            if (data_cnt_r == dlen_r) hdr_r <= 2'h0;
          end
          default: hdr_r <= 2'h0;
        endcase
      end
    end
  end

  // received data and identifier buffers
  logic take_id, take_data;
  assign take_id = rx_done && !ctrl_r.byte_mode && hdr_r == 2'h2;
  assign take_data = rx_done && (ctrl_r.byte_mode || hdr_r == 2'h3); // one byte, see (RL10)
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      idbuf_r <= 8'h00;
      rxd_r <= 8'h00;
    end else begin
      if (take_id) idbuf_r <= rx_sh_r; // kept on parity error too, see (RL14) see (RL15)
      if (take_data) rxd_r <= rx_sh_r;
    end
  end

  // ----------------------------------------
  // transmitter, 8-N-1, halted when byte mode drops
  // ----------------------------------------
  logic [3:0] tx_bit_r;
  logic [7:0] tx_bt_r;
  logic [9:0] tx_sh_r;
  logic tx_go;
  logic tx_end;
  assign tx_go = ce_in && wr_in && addr_in == `LSI_OFF_TXD && ctrl_r.byte_mode && !tx_busy_r;
  assign tx_end = run && tx_busy_r && tx_bt_r == bittime_r && tx_bit_r == 4'h9;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_busy_r <= 1'b0;
      tx_bit_r <= 4'h0;
      tx_bt_r <= 8'h00;
      tx_sh_r <= 10'h3FF;
      txd_r <= 8'h00;
    end else if (ce_in) begin
      if (tx_go) begin
        txd_r <= wdata_in;
        tx_sh_r <= {1'b1, wdata_in, 1'b0}; // see (RL11)
        tx_busy_r <= 1'b1;
        tx_bit_r <= 4'h0;
        tx_bt_r <= 8'h00;
      end else if (!ctrl_r.byte_mode || !ctrl_r.enable) begin
        tx_busy_r <= 1'b0; // see (RL9)
        tx_sh_r <= 10'h3FF;
      end else if (run && tx_busy_r) begin
        tx_bt_r <= tx_bt_r + 8'h01;
        if (tx_bt_r == bittime_r) begin // see (RL7)
          tx_bt_r <= 8'h00;
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_end) tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt sources, set wins over clear
  // ----------------------------------------
  logic rd_id, rd_rx, rd_sv, was_stop_r, bit_err;
  assign rd_id = ce_in && rd_in && addr_in == `LSI_OFF_IDBUF;
  assign rd_rx = ce_in && rd_in && addr_in == `LSI_OFF_RXD;
  assign rd_sv = ce_in && rd_in && addr_in == `LSI_OFF_SV;
  // compared at the bit's end: the echo lags by the output flop, two sync flops and the filter
  assign bit_err = run && tx_busy_r && tx_bt_r == bittime_r && rx_f_r != tx_sh_r[0];
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      src_r <= lsi_pkg::lsi_src_t'(8'h00);
      was_stop_r <= 1'b0;
    end else if (ce_in) begin
      was_stop_r <= stop_in;
      // reading the vector acknowledges the frame, wake, idpar, biterr or ovr source it showed
      if (rd_sv && sv_r == `LSI_SV_FRAME) src_r.frame <= 1'b0;
      if (rd_sv && sv_r == `LSI_SV_WAKE) src_r.wake <= 1'b0;
      if (rd_sv && sv_r == `LSI_SV_IDPAR) src_r.idpar <= 1'b0;
      if (rd_sv && sv_r == `LSI_SV_BITERR) src_r.biterr <= 1'b0;
      if (rd_sv && sv_r == `LSI_SV_OVR) src_r.ovr <= 1'b0;
      if (rd_id) src_r.idok <= 1'b0; // see (RL14)
      if (rd_rx) src_r.rxf <= 1'b0;
      src_r.txe <= ctrl_r.byte_mode && !tx_busy_r && !tx_go;
      if (rx_done && !rx_stop_ok) src_r.frame <= 1'b1; // see (RL13)
      if (take_id && id_par_ok) src_r.idok <= 1'b1; // see (RL14)
      if (take_id && !id_par_ok) src_r.idpar <= 1'b1; // see (RL15)
      if (was_stop_r && !stop_in) src_r.wake <= 1'b1; // see (RL17)
      if (take_data && rx_stop_ok) src_r.rxf <= 1'b1;
      if (take_data && src_r.rxf && !rd_rx) src_r.ovr <= 1'b1;
      if (bit_err) src_r.biterr <= 1'b1;
    end
  end

  // priority encoder; byte mode masks the lin-only sources
  always_comb begin
    sv_nxt = `LSI_SV_NONE; // see (RL20)
    if (ctrl_r.byte_mode) begin
      if (src_r.txe) sv_nxt = `LSI_SV_TXE; // see (RL18) see (RL19)
      if (src_r.rxf) sv_nxt = `LSI_SV_RXF;
      if (src_r.biterr) sv_nxt = `LSI_SV_BITERR;
      if (src_r.ovr) sv_nxt = `LSI_SV_OVR;
    end else begin
      if (src_r.frame) sv_nxt = `LSI_SV_FRAME;
      if (src_r.wake) sv_nxt = `LSI_SV_WAKE;
      if (src_r.idpar) sv_nxt = `LSI_SV_IDPAR;
      if (src_r.rxf) sv_nxt = `LSI_SV_RXF;
      if (src_r.biterr) sv_nxt = `LSI_SV_BITERR;
      if (src_r.ovr) sv_nxt = `LSI_SV_OVR;
      if (src_r.idok) sv_nxt = `LSI_SV_IDOK;
    end
  end

  // ----------------------------------------
  // outputs and read port
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sv_r <= 8'h00;
      sv_out <= 8'h00;
      lin_tx_out <= 1'b1;
      lin_tx_oe_out <= 1'b0;
      mod_clk_en_out <= 1'b0;
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      sv_r <= sv_nxt;
      sv_out <= sv_nxt;
      lin_tx_out <= tx_busy_r ? tx_sh_r[0] : 1'b1;
      lin_tx_oe_out <= tx_busy_r && !tx_sh_r[0]; // open drain, drives dominant only
      mod_clk_en_out <= run;
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `LSI_OFF_CTRL2: rdata_out <= {1'b0, ctrl_r.prescale, ctrl_r.wait_clock, ctrl_r.byte_mode, 1'b0, ctrl_r.enable};
          `LSI_OFF_BITTIME: rdata_out <= bittime_r;
          `LSI_OFF_DLEN: rdata_out <= {4'h0, dlen_r};
          `LSI_OFF_IDBUF: rdata_out <= idbuf_r;
          `LSI_OFF_SV: rdata_out <= sv_r;
          `LSI_OFF_TXD: rdata_out <= txd_r;
          `LSI_OFF_RXD: rdata_out <= rxd_r;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/lsi_lin_master.sv ====
// lin master model: sends and receives 8-N-1 bytes on the wired bus
`timescale 1ns/1ps
`default_nettype none
module lsi_lin_master (
  // clock
  input wire logic clk_in,
  // bus
  input wire logic bus_in,
  output logic drv_out
);
  // released line is pulled up, so recessive is simply 1
  initial drv_out = 1'b1;
  // start bit, eight data bits lsb first, one stop bit
  task automatic send(input logic [7:0] v, input int bt);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in) drv_out <= f[i];
      repeat (bt - 1) @(posedge clk_in);
    end
    @(posedge clk_in) drv_out <= 1'b1;
  endtask
  // short dominant pulse that a filter must swallow
  task automatic glitch(input int n);
    @(posedge clk_in) drv_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    drv_out <= 1'b1;
  endtask
  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv(input int bt, output logic [7:0] v, output logic stop_bit);
    int n;
    n = 0;
    while (bus_in && n < 1000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (bt / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk_in);
      v[i] = bus_in;
    end
    repeat (bt) @(posedge clk_in);
    stop_bit = bus_in;
  endtask
endmodule
`default_nettype wire

// ==== sim/lsi_monitor.sv ====
// assertion checker bound to the lin slave interface top
`timescale 1ns/1ps
`default_nettype none
module lsi_monitor (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // system, pin, status
  input wire logic cpu_wait_in,
  input wire logic stop_in,
  input wire logic lin_tx_out,
  input wire logic lin_tx_oe_out,
  input wire logic mod_clk_en_out,
  input wire logic [7:0] sv_out
);
  logic [7:0] ctrl_q;
  logic wcm_done_q;
  logic run_c;
  // control shadow; bit 3 keeps its first written value until reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 8'h00;
      wcm_done_q <= 1'b0;
    end else if (ce_in && wr_in && addr_in == 4'h0) begin
      ctrl_q <= {1'b0, wdata_in[6:4], wcm_done_q ? ctrl_q[3] : wdata_in[3], wdata_in[2:0]};
      wcm_done_q <= 1'b1;
    end
  end
  // module clock wanted: enabled and not stopped by cpu wait
  assign run_c = ctrl_q[0] && (!cpu_wait_in || ctrl_q[3]);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_released;
    !lin_tx_oe_out [*8];
  endsequence
  property p_ctrl_read;
    $past(rd_in && addr_in == 4'h0) |-> {rdata_out[6:2], rdata_out[0]} == {$past(ctrl_q[6:2]), $past(ctrl_q[0])};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
  property p_mod_on;
    run_c && $past(run_c) |-> mod_clk_en_out;
  endproperty
  a_mod_on: assert property (p_mod_on) else $error("module clock not running");
  property p_wait_off;
    cpu_wait_in && !ctrl_q[3] && $past(cpu_wait_in && !ctrl_q[3]) |-> !mod_clk_en_out;
  endproperty
  a_wait_off: assert property (p_wait_off) else $error("module clock runs in wait");
  property p_mod_off;
    !ctrl_q[0] && $past(!ctrl_q[0]) |-> !mod_clk_en_out;
  endproperty
  a_mod_off: assert property (p_mod_off) else $error("module clock runs while disabled");
  property p_halt;
    $fell(ctrl_q[2]) |-> ##[1:3] s_released;
  endproperty
  a_halt: assert property (p_halt) else $error("transmit not halted");
  property p_oe;
    lin_tx_oe_out |-> !lin_tx_out;
  endproperty
  a_oe: assert property (p_oe) else $error("driver enabled on recessive level");
  property p_wake;
    $fell(stop_in) && !ctrl_q[2] |-> ##[1:4] sv_out >= 8'h08;
  endproperty
  a_wake: assert property (p_wake) else $error("wake source missing");
  property p_subset;
    ctrl_q[2] && $past(ctrl_q[2]) && $past(ctrl_q[2], 2) && $past(ctrl_q[2], 3) |->
      sv_out inside {8'h00, 8'h0C, 8'h14, 8'h18, 8'h1C};
  endproperty
  a_subset: assert property (p_subset) else $error("lin source shown in byte mode");
  property p_txe;
    sv_out == 8'h0C |-> ctrl_q[2] || $past(ctrl_q[2]) || $past(ctrl_q[2], 2) || $past(ctrl_q[2], 3);
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty outside byte mode");
  property p_legal;
    sv_out[1:0] == 2'b00 && sv_out <= 8'h20;
  endproperty
  a_legal: assert property (p_legal) else $error("status vector code illegal");
endmodule
bind lsi_top lsi_monitor i_lsi_monitor (.clock_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .cpu_wait_in, .stop_in, .lin_tx_out, .lin_tx_oe_out, .mod_clk_en_out, .sv_out);
`default_nettype wire

// ==== sim/lsi_top_bench.sv ====
// testbench of the lin slave interface against a lin master model
`timescale 1ns/1ps
`default_nettype none
module lsi_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cwait = 1'b0;
  logic stop = 1'b0;
  logic [7:0] rdata;
  logic [7:0] sv;
  logic tx;
  logic oe;
  logic mclk;
  logic mdrv;
  logic bus;
  logic [7:0] d;
  logic sb;
  int n_errors = 0;
  int cmp_count = 0;
  // wired-and bus with pull-up; design pulls low only while enabled
  assign bus = mdrv & ~(oe & ~tx);
  lsi_top i_lsi_top (.clock_in(clk), .rst_in(rst), .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .cpu_wait_in(cwait), .stop_in(stop), .lin_rx_in(bus), .lin_tx_out(tx),
    .lin_tx_oe_out(oe), .mod_clk_en_out(mclk), .sv_out(sv));
  lsi_lin_master i_lsi_lin_master (.clk_in(clk), .bus_in(bus), .drv_out(mdrv));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // reset values, wait clock mode written once before enabling
  task automatic t_ctrl;
    chk(sv, 8'h00);
    chk({7'h00, mclk}, 8'h00);
    rd_reg(4'h1, d);
    chk(d, 8'h10);
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h0, 8'h01);
    rd_reg(4'h0, d);
    chk(d, 8'h09);
    @(posedge clk) cwait <= 1'b1;
    cyc(3);
    chk({7'h00, mclk}, 8'h01);
    @(posedge clk) cwait <= 1'b0;
  endtask
  task automatic t_wake;
    @(posedge clk) stop <= 1'b1;
    cyc(3);
    @(posedge clk) stop <= 1'b0;
    cyc(4);
    chk(sv, 8'h08);
    rd_reg(4'h4, d);
    chk(d, 8'h08);
    cyc(4);
    chk(sv, 8'h00);
  endtask
  // long data length must still send a single byte
  task automatic t_tx;
    wr_reg(4'h1, 8'h07);
    wr_reg(4'h2, 8'h07);
    wr_reg(4'h0, 8'h0D);
    cyc(4);
    chk(sv, 8'h0C);
    fork
      wr_reg(4'h5, 8'hA5);
      i_lsi_lin_master.recv(8, d, sb);
    join
    chk(d, 8'hA5);
    chk({7'h00, sb}, 8'h01);
    cyc(40);
    rd_reg(4'h6, d);
    cyc(4);
    chk(sv, 8'h0C);
  endtask
  // receive, then overrun outranks rx full
  task automatic t_rx;
    i_lsi_lin_master.send(8'h3C, 8);
    cyc(4);
    chk(sv, 8'h14);
    rd_reg(4'h6, d);
    chk(d, 8'h3C);
    i_lsi_lin_master.send(8'h11, 8);
    i_lsi_lin_master.send(8'h22, 8);
    cyc(4);
    chk(sv, 8'h1C);
    rd_reg(4'h4, d);
    rd_reg(4'h6, d);
    cyc(4);
    chk(sv, 8'h0C);
  endtask
  task automatic t_filter;
    wr_reg(4'h1, 8'h1F);
    wr_reg(4'h0, 8'h3D);
    i_lsi_lin_master.glitch(3);
    cyc(400);
    chk(sv, 8'h0C);
    i_lsi_lin_master.send(8'h5A, 32);
    rd_reg(4'h6, d);
    chk(d, 8'h5A);
  endtask
  // leaving byte mode mid-byte releases the pin for good
  task automatic t_halt;
    wr_reg(4'h1, 8'h07);
    wr_reg(4'h0, 8'h0D);
    wr_reg(4'h5, 8'h00);
    cyc(20);
    chk({7'h00, oe}, 8'h01);
    wr_reg(4'h0, 8'h09);
    cyc(3);
    repeat (60) begin
      chk({6'h00, oe, tx}, 8'h01);
      cyc(1);
    end
  endtask
  // break, delimiter, sync and protected identifier
  task automatic lin_header(input logic [7:0] pid);
    i_lsi_lin_master.glitch(120);
    cyc(8);
    i_lsi_lin_master.send(8'h55, 8);
    i_lsi_lin_master.send(pid, 8);
    cyc(4);
  endtask
  // good identifier with one data byte, then a bad one whose frame is dropped
  task automatic t_lin;
    wr_reg(4'h2, 8'h00);
    lin_header(8'hC1);
    chk(sv, 8'h20);
    rd_reg(4'h3, d);
    chk(d, 8'hC1);
    cyc(4);
    chk(sv, 8'h04);
    rd_reg(4'h4, d);
    i_lsi_lin_master.send(8'h66, 8);
    rd_reg(4'h6, d);
    chk(d, 8'h66);
    lin_header(8'h41);
    chk(sv, 8'h10);
    rd_reg(4'h3, d);
    chk(d, 8'h41);
    i_lsi_lin_master.send(8'h99, 8);
    rd_reg(4'h6, d);
    chk(d, 8'h66);
  endtask
  task automatic t_wait_stop;
    @(posedge clk) rst <= 1'b1;
    cyc(2);
    @(posedge clk) rst <= 1'b0;
    wr_reg(4'h0, 8'h01);
    @(posedge clk) cwait <= 1'b1;
    cyc(3);
    chk({7'h00, mclk}, 8'h00);
    @(posedge clk) cwait <= 1'b0;
    wr_reg(4'h0, 8'h00);
    cyc(3);
    chk({7'h00, mclk}, 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_ctrl;
    t_wake;
    t_tx;
    t_rx;
    t_filter;
    t_halt;
    t_lin;
    t_wait_stop;
    end_of_test;
  end
  // watchdog; the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
